// ===== cmbsc_addr_map.sv
// Program and data space decoders with cross-mapping of RAM and flash.
`timescale 1ns/1ps
`include "cmbsc_cfg.svh"
module cmbsc_addr_map
   import cmbsc_pkg::*;
(
   // Addresses and mapping controls
   input wire logic [15:0] prog_addr_in,
   input wire logic [15:0] data_addr_in,
   input wire logic ram_in_prog_in,
   input wire logic flash_in_data_in,
   // Memory read data
   input wire logic [15:0] prog_flash_in,
   input wire logic [15:0] prog_rom_in,
   input wire logic [15:0] prog_ram_in,
   input wire logic [15:0] data_ram_in,
   input wire logic [15:0] data_flash_in,
   // Selected words
   output logic [15:0] instr_out,
   output logic [15:0] rdata_out,
   output logic data_is_ram_out
);
   // Program and data addresses are decoded apart; register space never appears here.
   wire p_flash = prog_addr_in <= `CMBSC_FLASH_TOP;
   wire p_rom = prog_addr_in >= `CMBSC_ROM_BASE && prog_addr_in <= `CMBSC_ROM_TOP;
   wire p_ram = ram_in_prog_in && prog_addr_in >= `CMBSC_PRAM_BASE
      && prog_addr_in <= `CMBSC_PRAM_TOP;
   wire d_ram = data_addr_in <= `CMBSC_DRAM_TOP;
   wire d_flash = flash_in_data_in && data_addr_in >= `CMBSC_DFLASH_BASE;

   // Unmapped fetches execute as no-operation so a stray jump cannot run garbage.
   assign instr_out = p_flash ? prog_flash_in : p_rom ? prog_rom_in
      : p_ram ? prog_ram_in : `CMBSC_NOP_WORD;
   assign rdata_out = d_ram ? data_ram_in : d_flash ? data_flash_in : `CMBSC_CLEAR_WORD;
   assign data_is_ram_out = d_ram;
endmodule

// ===== cmbsc_cfg.svh
// Address map, reset values and encodings of the core memory and boot control.
`ifndef CMBSC_CFG_SVH
`define CMBSC_CFG_SVH
`define CMBSC_FLASH_TOP 16'h7FFF
`define CMBSC_ROM_BASE 16'h8000
`define CMBSC_ROM_TOP 16'h8FFF
`define CMBSC_PRAM_BASE 16'hA000
`define CMBSC_PRAM_TOP 16'hA3FF
`define CMBSC_DRAM_TOP 16'h03FF
`define CMBSC_DFLASH_BASE 16'h8000
`define CMBSC_KEY_SCAN_BASE 16'h8010
`define CMBSC_KEY_BASE 16'h0010
`define CMBSC_KEY_TOP 16'h001F
`define CMBSC_KEY_LAST_IDX 4'hF
`define CMBSC_ERASED_WORD 16'hFFFF
`define CMBSC_CLEAR_WORD 16'h0000
`define CMBSC_NOP_WORD 16'h0000
`define CMBSC_STACK_PTR_RESET 4'hF
`define CMBSC_LOCK_RESET 1'b1
`define CMBSC_IE_RESET 1'b0
`define CMBSC_MAP_RESET 2'h0
`define CMBSC_BOOT_RESET 2'h0
`define CMBSC_BOOT_JTAG 2'h0
`define CMBSC_BOOT_I2C 2'h1
`define CMBSC_LAST_MODULE 4'h5
`define CMBSC_PM_INC 2'h1
`define CMBSC_PM_DEC 2'h2
`define CMBSC_SYS_LOCK 4'h0
`define CMBSC_SYS_BOOT 4'h1
`define CMBSC_SYS_MAP 4'h2
`define CMBSC_SYS_IE 4'h3
`define CMBSC_SUB_SUBR_RETURN 4'h0
`define CMBSC_SUB_INT_RETURN 4'h1
`define CMBSC_SUB_PUSH 4'h2
`define CMBSC_SUB_POP 4'h3
`define CMBSC_SUB_POP_INT 4'h4
`define CMBSC_FL_PROG 4'h0
`define CMBSC_FL_ERASE 4'h1
`endif

// ===== cmbsc_core.sv
// Core fetch/execute, memory mapping, boot entry, key lock and boot source control.
`timescale 1ns/1ps
`include "cmbsc_cfg.svh"
module cmbsc_core
   import cmbsc_pkg::*;
#(
   parameter int NUM_ACC = 16,
   parameter int NUM_PTR = 3,
   parameter int KEY_WORDS = 16
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Program space read data
   input wire logic [15:0] prog_flash_in,
   input wire logic [15:0] prog_rom_in,
   input wire logic [15:0] prog_ram_in,
   // Data space read data
   input wire logic [15:0] data_ram_in,
   input wire logic [15:0] data_flash_in,
   // Interrupt request from the interrupt logic
   input wire logic int_req_in,
   input wire logic [15:0] int_vector_in,
   // Host pins, asynchronous to the core clock
   input wire logic host_req_in,
   input wire logic [1:0] host_if_in,
   input wire logic host_key_valid_in,
   input wire logic [15:0] host_key_word_in,
   // Program fetch
   output logic [15:0] pc_out,
   // Data space access
   output logic [15:0] data_addr_out,
   output logic data_wr_out,
   output logic [15:0] data_wr_addr_out,
   output logic [15:0] data_wdata_out,
   // Peripheral register modules
   output logic periph_wr_out,
   output logic [2:0] periph_module_out,
   output logic [4:0] periph_reg_out,
   output logic [15:0] periph_wdata_out,
   // Flash self programming
   output logic flash_prog_out,
   output logic flash_erase_out,
   output logic [15:0] flash_addr_out,
   output logic [15:0] flash_wdata_out,
   // Protection and boot source
   output logic protection_lock_bit_out,
   output logic [1:0] boot_source_select_out,
   output logic jtag_boot_sel_out,
   output logic i2c_boot_sel_out,
   output logic host_access_ok_out,
   output logic host_grant_out,
   output logic host_refused_out,
   // Core status
   output logic [3:0] stack_pointer_out,
   output logic int_ack_out,
   output logic core_running_out
);
   localparam int HOST_W = 20;

   cmbsc_state_type state;
   cmbsc_state_type next_state;
   cmbsc_op_type op;
   cmbsc_stk_type stk_op;
   logic [15:0] acc [NUM_ACC];
   logic [15:0] dp [NUM_PTR];
   logic [15:0] next_dp [NUM_PTR];
   logic [15:0] key [KEY_WORDS];
   logic [KEY_WORDS-1:0] key_ones;
   logic [KEY_WORDS-1:0] key_zero;
   logic [3:0] ap;
   logic [1:0] dsel;
   logic [1:0] next_dsel;
   logic [1:0] map_ctl;
   logic [1:0] next_map;
   logic [1:0] next_boot;
   logic ie;
   logic next_ie;
   logic next_lock;
   logic [3:0] scan_cnt;
   logic [3:0] key_idx;
   logic key_good;
   logic key_matched;
   logic [HOST_W-1:0] host_raw;
   logic [HOST_W-1:0] hs1;
   logic [HOST_W-1:0] hs2;
   logic [HOST_W-1:0] hs3;
   logic [HOST_W-1:0] hstable;
   logic req_prev;
   logic kv_prev;
   logic [15:0] instr;
   logic [15:0] rdata;
   logic [15:0] stk_rdata;
   logic [15:0] stk_wdata;
   logic [15:0] next_pc;
   logic [15:0] next_data_addr;
   logic [15:0] acc_wdata;
   logic data_is_ram;

   if (NUM_ACC != 16 || KEY_WORDS != 16 || NUM_PTR < 1 || NUM_PTR > 4) begin : g_param_check
      $error("cmbsc_core needs 16 accumulators, 16 key words and 1 to 4 pointers");
   end

   // Decode: opcode, register field and immediate sit in one fixed word.
   wire [3:0] fld = instr[11:8];
   wire [7:0] imm = instr[7:0];
   assign op = cmbsc_op_type'(instr[15:12]);
   wire run = (state == ST_RUN);
   wire take_int = run && ie && int_req_in;
   wire exec = run && !take_int;
   wire [15:0] acc_a = acc[ap];
   wire [15:0] acc_f = acc[fld];
   wire is_ld = exec && op == OP_LOAD_DATA;
   wire is_st = exec && op == OP_STORE_DATA;
   wire is_mem = is_ld || is_st;
   wire pm_inc = imm[1:0] == `CMBSC_PM_INC;
   wire pm_dec = imm[1:0] == `CMBSC_PM_DEC;
   wire is_setp = exec && op == OP_SET_PTR && fld < 4'(NUM_PTR);
   wire is_call = exec && op == OP_CALL;
   wire is_stk = exec && op == OP_STACK;
   wire is_sys = exec && op == OP_SYS;
   wire is_flash = exec && op == OP_FLASH;

   // Stack traffic: calls, pushes and interrupt entry push; returns and pops pop.
   wire do_push = take_int || is_call || (is_stk && fld == `CMBSC_SUB_PUSH);
   wire do_subr_ret = is_stk && fld == `CMBSC_SUB_SUBR_RETURN;
   wire do_int_ret = is_stk && fld == `CMBSC_SUB_INT_RETURN;
   wire do_pop_int = is_stk && fld == `CMBSC_SUB_POP_INT;
   wire do_pop_acc = do_pop_int || (is_stk && fld == `CMBSC_SUB_POP);
   wire do_pop = do_subr_ret || do_int_ret || do_pop_acc;
   assign stk_op = do_push ? STK_PUSH : do_pop ? STK_POP : STK_HOLD;
   wire [15:0] pc_inc = pc_out + 16'h0001;
   // An interrupt pushes the address of the instruction it displaced.
   assign stk_wdata = take_int ? pc_out : is_call ? pc_inc : acc_a;

   // Every executed word moves the counter in the same cycle; there is no pipeline.
   assign next_pc = !run ? pc_out
      : take_int ? int_vector_in
      : (is_call || (exec && op == OP_JUMP)) ? acc_a
      : (do_subr_ret || do_int_ret) ? stk_rdata
      : pc_inc;

   wire acc_we = do_pop_acc || (exec && (op == OP_LOAD_IMM || op == OP_ADD
      || op == OP_AND || op == OP_OR || op == OP_LOAD_DATA));
   assign acc_wdata = (op == OP_LOAD_IMM) ? {8'h00, imm}
      : (op == OP_ADD) ? acc_a + acc_f
      : (op == OP_AND) ? acc_a & acc_f
      : (op == OP_OR) ? acc_a | acc_f
      : (op == OP_LOAD_DATA) ? rdata
      : stk_rdata;
   wire [3:0] next_ap = (exec && op == OP_SEL_ACC) ? fld : ap;

   assign next_dsel = is_setp ? fld[1:0] : dsel;
   assign next_ie = take_int ? 1'b0
      : (do_int_ret || do_pop_int) ? 1'b1
      : (is_sys && fld == `CMBSC_SYS_IE) ? imm[0] : ie;
   assign next_lock = (is_sys && fld == `CMBSC_SYS_LOCK) ? imm[0] : protection_lock_bit_out;
   assign next_boot = (is_sys && fld == `CMBSC_SYS_BOOT) ? imm[1:0] : boot_source_select_out;
   assign next_map = (is_sys && fld == `CMBSC_SYS_MAP) ? imm[1:0] : map_ctl;

   // Firmware self-update goes through the flash controller outside this block.
   wire fl_prog = is_flash && fld == `CMBSC_FL_PROG;
   wire fl_erase = is_flash && fld == `CMBSC_FL_ERASE;
   wire [15:0] fl_addr = dp[dsel];
   wire fl_key = fl_addr >= `CMBSC_KEY_BASE && fl_addr <= `CMBSC_KEY_TOP;

   // Boot scan copies the flash key into a shadow before the first fetch.
   wire scan_last = (scan_cnt == `CMBSC_KEY_LAST_IDX);
   always_comb begin
      case (state)
         ST_SCAN: next_state = scan_last ? ST_RUN : ST_SCAN;
         ST_RUN: next_state = ST_RUN;
         default: next_state = ST_SCAN;
      endcase
   end
   assign next_data_addr = (next_state == ST_SCAN)
      ? `CMBSC_KEY_SCAN_BASE + {12'h000, scan_cnt + 4'h1}
      : next_dp[next_dsel];

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         state <= ST_SCAN;
         scan_cnt <= 4'h0;
         pc_out <= `CMBSC_ROM_BASE;
         data_addr_out <= `CMBSC_KEY_SCAN_BASE;
      end else begin
         state <= next_state;
         scan_cnt <= (state == ST_SCAN) ? scan_cnt + 4'h1 : scan_cnt;
         pc_out <= next_pc;
         data_addr_out <= next_data_addr;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         ap <= 4'h0;
         dsel <= 2'h0;
         ie <= `CMBSC_IE_RESET;
         map_ctl <= `CMBSC_MAP_RESET;
         protection_lock_bit_out <= `CMBSC_LOCK_RESET;
         boot_source_select_out <= `CMBSC_BOOT_RESET;
      end else begin
         ap <= next_ap;
         dsel <= next_dsel;
         ie <= next_ie;
         map_ctl <= next_map;
         protection_lock_bit_out <= next_lock;
         boot_source_select_out <= next_boot;
      end
   end

   for (genvar i = 0; i < NUM_ACC; i++) begin : g_acc
      always_ff @(posedge ref_clk_in) begin
         if (rst_in) begin
            acc[i] <= `CMBSC_CLEAR_WORD;
         end else if (acc_we && ap == 4'(i)) begin
            acc[i] <= acc_wdata;
         end
      end
   end

   for (genvar j = 0; j < NUM_PTR; j++) begin : g_ptr
      wire sel_set = is_setp && fld[1:0] == 2'(j);
      wire sel_mod = is_mem && dsel == 2'(j);
      assign next_dp[j] = sel_set ? acc_a
         : (sel_mod && pm_inc) ? dp[j] + 16'h0001
         : (sel_mod && pm_dec) ? dp[j] - 16'h0001
         : dp[j];
      always_ff @(posedge ref_clk_in) begin
         if (rst_in) begin
            dp[j] <= `CMBSC_CLEAR_WORD;
         end else begin
            dp[j] <= next_dp[j];
         end
      end
   end

   for (genvar k = 0; k < KEY_WORDS; k++) begin : g_key
      assign key_ones[k] = (key[k] == `CMBSC_ERASED_WORD);
      assign key_zero[k] = (key[k] == `CMBSC_CLEAR_WORD);
      always_ff @(posedge ref_clk_in) begin
         if (rst_in) begin
            key[k] <= `CMBSC_ERASED_WORD;
         end else if (state == ST_SCAN && scan_cnt == 4'(k)) begin
            key[k] <= rdata;
         end else if (fl_erase) begin
            key[k] <= `CMBSC_ERASED_WORD;
         end else if (fl_prog && fl_key && fl_addr[3:0] == 4'(k)) begin
            key[k] <= acc_a;
         end
      end
   end

   // Host pins pass three flops; a bit counts once the last two agree.
   assign host_raw = {host_key_word_in, host_if_in, host_key_valid_in, host_req_in};
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         hs1 <= '0;
         hs2 <= '0;
         hs3 <= '0;
         hstable <= '0;
         req_prev <= 1'b0;
         kv_prev <= 1'b0;
      end else begin
         hs1 <= host_raw;
         hs2 <= hs1;
         hs3 <= hs2;
         hstable <= (hs3 & ~(hs2 ^ hs3)) | (hstable & (hs2 ^ hs3));
         req_prev <= hstable[0];
         kv_prev <= hstable[1];
      end
   end
   wire [1:0] h_if = hstable[3:2];
   wire [15:0] h_word = hstable[19:4];
   wire if_ok = (h_if == boot_source_select_out);
   wire req_rise = hstable[0] && !req_prev;
   wire kv_rise = hstable[1] && !kv_prev && if_ok && run;
   wire word_ok = (h_word == key[key_idx]);
   wire key_blank = (&key_ones) || (&key_zero);
   // A cleared lock opens everything; otherwise a blank key or a matched key does.
   wire access_ok = !protection_lock_bit_out || key_blank || key_matched;
   wire grant = req_rise && run && if_ok && access_ok;

   // Key words are compared in order; a full pass with no mismatch unlocks.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         key_idx <= 4'h0;
         key_good <= 1'b1;
         key_matched <= 1'b0;
      end else if (kv_rise) begin
         key_idx <= key_idx + 4'h1;
         key_good <= (key_idx == `CMBSC_KEY_LAST_IDX) ? 1'b1 : key_good && word_ok;
         if (key_idx == `CMBSC_KEY_LAST_IDX) begin
            key_matched <= key_good && word_ok;
         end
      end
   end

   // Strobes are posted one cycle after the instruction; data fields are valid with them.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         data_wr_out <= 1'b0;
         data_wr_addr_out <= `CMBSC_CLEAR_WORD;
         data_wdata_out <= `CMBSC_CLEAR_WORD;
         periph_wr_out <= 1'b0;
         periph_module_out <= 3'h0;
         periph_reg_out <= 5'h00;
         periph_wdata_out <= `CMBSC_CLEAR_WORD;
         flash_prog_out <= 1'b0;
         flash_erase_out <= 1'b0;
         flash_addr_out <= `CMBSC_CLEAR_WORD;
         flash_wdata_out <= `CMBSC_CLEAR_WORD;
      end else begin
         data_wr_out <= is_st && data_is_ram;
         data_wr_addr_out <= data_addr_out;
         data_wdata_out <= acc_a;
         periph_wr_out <= exec && op == OP_PERIPH_WR && fld <= `CMBSC_LAST_MODULE;
         periph_module_out <= fld[2:0];
         periph_reg_out <= imm[4:0];
         periph_wdata_out <= acc_a;
         flash_prog_out <= fl_prog;
         flash_erase_out <= fl_erase;
         flash_addr_out <= fl_addr;
         flash_wdata_out <= acc_a;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         jtag_boot_sel_out <= 1'b1;
         i2c_boot_sel_out <= 1'b0;
         host_access_ok_out <= 1'b0;
         host_grant_out <= 1'b0;
         host_refused_out <= 1'b0;
         int_ack_out <= 1'b0;
         core_running_out <= 1'b0;
      end else begin
         jtag_boot_sel_out <= (next_boot == `CMBSC_BOOT_JTAG);
         i2c_boot_sel_out <= (next_boot == `CMBSC_BOOT_I2C);
         host_access_ok_out <= run && access_ok;
         host_grant_out <= grant;
         host_refused_out <= req_rise && if_ok && !grant;
         int_ack_out <= take_int;
         core_running_out <= (next_state == ST_RUN);
      end
   end

   cmbsc_addr_map u_map (
      .prog_addr_in(pc_out),
      .data_addr_in(data_addr_out),
      .ram_in_prog_in(map_ctl[0]),
      .flash_in_data_in(map_ctl[1] || state == ST_SCAN),
      .prog_flash_in(prog_flash_in),
      .prog_rom_in(prog_rom_in),
      .prog_ram_in(prog_ram_in),
      .data_ram_in(data_ram_in),
      .data_flash_in(data_flash_in),
      .instr_out(instr),
      .rdata_out(rdata),
      .data_is_ram_out(data_is_ram)
   );

   cmbsc_stack #(
      .DEPTH(16),
      .WIDTH(16)
   ) u_stack (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .op_in(stk_op),
      .wdata_in(stk_wdata),
      .rdata_out(stk_rdata),
      .stack_pointer_out(stack_pointer_out)
   );
endmodule

// ===== cmbsc_core_checker.sv
// Port-level assertions on the core memory and boot control.
`timescale 1ns/1ps
module cmbsc_core_checker (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Watched outputs
   input wire logic [15:0] pc_out,
   input wire logic data_wr_out,
   input wire logic [15:0] data_wr_addr_out,
   input wire logic periph_wr_out,
   input wire logic [2:0] periph_module_out,
   input wire logic protection_lock_bit_out,
   input wire logic [1:0] boot_source_select_out,
   input wire logic jtag_boot_sel_out,
   input wire logic i2c_boot_sel_out,
   input wire logic host_grant_out,
   input wire logic host_refused_out,
   input wire logic [3:0] stack_pointer_out,
   input wire logic core_running_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   // The key scan keeps the core parked for sixteen cycles after release.
   sequence scan_quiet;
      (!core_running_out) [*8];
   endsequence
   reset_pc_a: assert property (rst_in |=> pc_out == 16'h8000)
      else $error("pc not at rom base after reset");
   reset_lock_a: assert property (rst_in |=> protection_lock_bit_out)
      else $error("lock bit clear after reset");
   reset_sp_a: assert property (rst_in |=> stack_pointer_out == 4'hF)
      else $error("stack pointer not at top after reset");
   scan_len_a: assert property (disable iff (rst_in)
      $fell(rst_in) |-> scan_quiet ##[7:9] core_running_out) else $error("scan length wrong");
   rom_entry_a: assert property (disable iff (rst_in)
      $rose(core_running_out) |-> pc_out == 16'h8000) else $error("first fetch not at rom");
   sp_step_a: assert property (disable iff (rst_in)
      !$past(rst_in) |->
      4'(stack_pointer_out - $past(stack_pointer_out)) inside {4'h0, 4'h1, 4'hF})
      else $error("stack pointer jumped");
   store_ram_a: assert property (disable iff (rst_in)
      data_wr_out |-> data_wr_addr_out <= 16'h03FF) else $error("store outside ram");
   periph_mod_a: assert property (disable iff (rst_in)
      periph_wr_out |-> periph_module_out <= 3'h5) else $error("bad peripheral module");
   grant_ok_a: assert property (disable iff (rst_in)
      host_grant_out |-> core_running_out && !host_refused_out) else $error("bad grant");
   boot_sel_a: assert property (disable iff (rst_in) $stable(boot_source_select_out) |->
      jtag_boot_sel_out == (boot_source_select_out == 2'h0)
      && i2c_boot_sel_out == (boot_source_select_out == 2'h1)) else $error("boot decode wrong");
endmodule
bind cmbsc_core cmbsc_core_checker u_chk (.ref_clk_in, .rst_in, .pc_out, .data_wr_out,
   .data_wr_addr_out, .periph_wr_out, .periph_module_out, .protection_lock_bit_out,
   .boot_source_select_out, .jtag_boot_sel_out, .i2c_boot_sel_out, .host_grant_out,
   .host_refused_out, .stack_pointer_out, .core_running_out);

// ===== cmbsc_host_model.sv
// Behavioural programming host: access requests and key words.
`timescale 1ns/1ps
module cmbsc_host_model (
   // Clock and answers
   input wire logic ref_clk_in,
   input wire logic host_grant_out,
   input wire logic host_refused_out,
   // Host pins
   output logic host_req_in,
   output logic [1:0] host_if_in,
   output logic host_key_valid_in,
   output logic [15:0] host_key_word_in
);
   initial begin
      host_req_in = 1'b0;
      host_if_in = 2'h0;
      host_key_valid_in = 1'b0;
      host_key_word_in = 16'h0000;
   end
   // A request on the wrong interface gets no answer, so the wait is bounded.
   task automatic ask(input logic [1:0] ifc, output logic ans, output logic ok);
      ans = 1'b0;
      ok = 1'b0;
      @(negedge ref_clk_in);
      host_if_in = ifc;
      host_req_in = 1'b1;
      for (int i = 0; i < 12 && !ans; i++) begin
         @(posedge ref_clk_in);
         #1;
         ans = host_grant_out | host_refused_out;
         ok = host_grant_out;
      end
      @(negedge ref_clk_in);
      host_req_in = 1'b0;
      repeat (5) @(negedge ref_clk_in);
   endtask
   task automatic key(input logic [1:0] ifc, input logic [15:0] w);
      @(negedge ref_clk_in);
      host_if_in = ifc;
      host_key_word_in = w;
      repeat (4) @(negedge ref_clk_in);
      host_key_valid_in = 1'b1;
      repeat (6) @(negedge ref_clk_in);
      host_key_valid_in = 1'b0;
      repeat (4) @(negedge ref_clk_in);
      host_key_word_in = ~w;
      @(negedge ref_clk_in);
   endtask
endmodule

// ===== cmbsc_pkg.sv
// Shared types of the core memory and boot control.
package cmbsc_pkg;
   typedef enum logic [3:0] {
      OP_NOP = 4'h0, OP_LOAD_IMM = 4'h1, OP_SEL_ACC = 4'h2, OP_ADD = 4'h3,
      OP_AND = 4'h4, OP_OR = 4'h5, OP_LOAD_DATA = 4'h6, OP_STORE_DATA = 4'h7,
      OP_SET_PTR = 4'h8, OP_JUMP = 4'h9, OP_CALL = 4'hA, OP_STACK = 4'hB,
      OP_SYS = 4'hC, OP_PERIPH_WR = 4'hD, OP_FLASH = 4'hE, OP_SPARE = 4'hF
   } cmbsc_op_type;
   typedef enum logic [1:0] {ST_SCAN = 2'b01, ST_RUN = 2'b10} cmbsc_state_type;
   typedef enum logic [1:0] {STK_HOLD = 2'h0, STK_PUSH = 2'h1, STK_POP = 2'h2} cmbsc_stk_type;
endpackage

// ===== cmbsc_stack.sv
// Sixteen-entry hardware stack with a wrapping four-bit pointer.
`timescale 1ns/1ps
`include "cmbsc_cfg.svh"
module cmbsc_stack
   import cmbsc_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Stack request
   input wire cmbsc_stk_type op_in,
   input wire logic [WIDTH-1:0] wdata_in,
   // Stack state
   output logic [WIDTH-1:0] rdata_out,
   output logic [3:0] stack_pointer_out
);
   logic [WIDTH-1:0] entry [DEPTH];
   logic [3:0] next_sp;

   if (DEPTH != 16) begin : g_depth_check
      $error("cmbsc_stack serves exactly sixteen entries");
   end

   // The pointer simply wraps; software owns the depth budget.
   assign next_sp = (op_in == STK_PUSH) ? stack_pointer_out + 4'h1
      : (op_in == STK_POP) ? stack_pointer_out - 4'h1 : stack_pointer_out;
   assign rdata_out = entry[stack_pointer_out];

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         stack_pointer_out <= `CMBSC_STACK_PTR_RESET;
      end else begin
         stack_pointer_out <= next_sp;
      end
   end

   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge ref_clk_in) begin
         if (rst_in) begin
            entry[i] <= '0;
         end else if (op_in == STK_PUSH && next_sp == 4'(i)) begin
            entry[i] <= wdata_in;
         end
      end
   end
endmodule

// ===== tb_top.sv
// Self-checking testbench of the core memory and boot control.
`timescale 1ns/1ps
module tb_top;
   logic ref_clk_in, rst_in, ans, ok, data_wr_out, periph_wr_out, protection_lock_bit_out;
   logic jtag_boot_sel_out, i2c_boot_sel_out, host_grant_out, host_refused_out;
   logic core_running_out, host_req_in, host_key_valid_in;
   logic [15:0] prog_flash_in, prog_rom_in, data_flash_in, pc_out, data_addr_out;
   logic [15:0] data_wr_addr_out, data_wdata_out, periph_wdata_out, host_key_word_in;
   logic [1:0] host_if_in, boot_source_select_out;
   logic [2:0] periph_module_out;
   logic [4:0] periph_reg_out;
   logic [3:0] stack_pointer_out, sp_last;
   logic [15:0] rom [0:4095];
   logic [15:0] flash [0:255];
   logic [31:0] seed, wr_q[$], per_q[$];
   logic [3:0] sp_q[$];
   logic [7:0] r;
   int error_cnt, compares, n;
   cmbsc_core u_dut (.ref_clk_in, .rst_in, .prog_flash_in, .prog_rom_in,
      .prog_ram_in(16'h0000), .data_ram_in(16'h0000), .data_flash_in,
      .int_req_in(1'b0), .int_vector_in(16'h0000), .host_req_in, .host_if_in,
      .host_key_valid_in, .host_key_word_in, .pc_out, .data_addr_out, .data_wr_out,
      .data_wr_addr_out, .data_wdata_out, .periph_wr_out, .periph_module_out,
      .periph_reg_out, .periph_wdata_out, .flash_prog_out(), .flash_erase_out(),
      .flash_addr_out(), .flash_wdata_out(), .protection_lock_bit_out,
      .boot_source_select_out, .jtag_boot_sel_out, .i2c_boot_sel_out,
      .host_access_ok_out(), .host_grant_out, .host_refused_out, .stack_pointer_out,
      .int_ack_out(), .core_running_out);
   cmbsc_host_model u_host (.ref_clk_in, .host_grant_out, .host_refused_out, .host_req_in,
      .host_if_in, .host_key_valid_in, .host_key_word_in);
   initial begin
      ref_clk_in = 1'b0;
      forever #50 ref_clk_in = ~ref_clk_in;
   end
   // Memories answer within the cycle, updated away from the sampling edge.
   always @(negedge ref_clk_in) begin
      prog_rom_in <= rom[pc_out[11:0]];
      prog_flash_in <= flash[pc_out[7:0]];
      data_flash_in <= flash[data_addr_out[7:0]];
   end
   always @(posedge ref_clk_in) begin
      #1;
      if (rst_in === 1'b0 && data_wr_out === 1'b1)
         wr_q.push_back({data_wr_addr_out, data_wdata_out});
      if (rst_in === 1'b0 && periph_wr_out === 1'b1)
         per_q.push_back({periph_module_out, periph_reg_out, periph_wdata_out});
      if (stack_pointer_out !== sp_last) sp_q.push_back(stack_pointer_out);
      sp_last = stack_pointer_out;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task finish_test;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task wait_for(input int sel, input int bound);
      n = 0;
      while ((sel == 0 ? core_running_out !== 1'b1 : protection_lock_bit_out !== 1'b0)
            && n < bound) begin
         @(posedge ref_clk_in);
         #1;
         n++;
      end
      if (n == bound) begin
         error_cnt++;
         finish_test;
      end
   endtask
   task do_reset;
      rst_in = 1'b1;
      repeat (4) @(negedge ref_clk_in);
      rst_in = 1'b0;
   endtask
   initial begin
      {error_cnt, compares} = '0;
      sp_last = 4'hF;
      seed = xs(32'h5449);
      r = seed[7:0];
      for (int i = 0; i < 4096; i++) rom[i] = 16'h0000;
      // Load, push, clobber, pop, point, store, a peripheral write, then one to module 6 that is dropped.
      rom[0] = {8'h10, r};
      rom[1] = 16'hB200;
      rom[2] = 16'h1077;
      rom[3] = 16'hB300;
      rom[4] = 16'h8000;
      rom[5] = 16'h7001;
      rom[6] = 16'hD503;
      rom[7] = 16'hD603;
      rom[12'h200] = 16'hC000;
      rom[12'h201] = 16'hC101;
      // Key words are kept away from both blank patterns.
      for (int i = 0; i < 16; i++) begin
         seed = xs(seed);
         flash[16 + i] = {seed[15:2], 2'b10};
      end
      do_reset;
      check("pc", pc_out, 32'h8000);
      check("sp", stack_pointer_out, 32'hF);
      check("lock", protection_lock_bit_out, 32'h1);
      check("boot", {boot_source_select_out, jtag_boot_sel_out}, 32'h1);
      $display("test reset done");
      wait_for(0, 40);
      check("scan", n, 32'd16);
      u_host.ask(2'h0, ans, ok);
      check("locked", {ans, ok}, 32'h2);
      check("sp trace", {sp_q.size(), sp_q[0], sp_q[1]}, {32'd2, 4'h0, 4'hF});
      check("store", {wr_q.size(), wr_q[0]}, {32'd1, 8'h00, r, 8'h00, r});
      check("periph", {per_q.size(), per_q[0]}, {32'd1, 8'h00, 8'hA3, 8'h00, r});
      $display("test program done");
      for (int i = 0; i < 16; i++) u_host.key(2'h0, flash[16 + i]);
      u_host.ask(2'h0, ans, ok);
      check("matched", {ans, ok, protection_lock_bit_out}, 32'h7);
      $display("test key done");
      do_reset;
      wait_for(0, 40);
      wait_for(1, 700);
      repeat (3) @(negedge ref_clk_in);
      check("i2c", {boot_source_select_out, i2c_boot_sel_out, jtag_boot_sel_out}, 32'h6);
      u_host.ask(2'h1, ans, ok);
      check("free", {ans, ok}, 32'h3);
      u_host.ask(2'h0, ans, ok);
      check("wrong if", ans, 32'h0);
      $display("test unlock done");
      finish_test;
   end
endmodule
